// ==== rtl/boot_id_params.svh ====
// Offsets, field positions, reset values and counts for the identity and strap block
`ifndef BOOT_ID_PARAMS_SVH
`define BOOT_ID_PARAMS_SVH

// CPU word addresses
`define BOOT_STRAP_ADDR        16'h1C34
`define CLK_CONFIG_TWO_ADDR    16'h1C1F

// Identity word layout
`define ID_REV_MSB             31
`define ID_REV_LSB             28
`define ID_PART_MSB            27
`define ID_PART_LSB            12
`define ID_MAKER_MSB           11
`define ID_MAKER_LSB           1
`define ID_FIXED_BIT           0
`define ID_FIXED_VALUE         1'h1

// Boot strap register layout
`define STRAP_FIELD_MSB        10
`define STRAP_FIELD_LSB        5
`define STRAP_HI_MSB           10
`define STRAP_HI_LSB           9
`define STRAP_LO_MSB           8
`define STRAP_LO_LSB           5
`define STRAP_RESET            16'h0000

// Clock configuration two layout
`define CLK_SRC_STATE_BIT      2
`define CLK_CONFIG_TWO_RESET   16'h0000

// Capture timing, in system clock edges after the reset pin rises
`define SYNC_EDGES             4'h2
`define STRAP_HI_EDGE          4'hA

`endif

// ==== rtl/boot_id_pkg.sv ====
// Types shared by the identity and boot strap block
package boot_id_pkg;

  typedef enum logic [2:0] {
    FREQ_OSC_12,
    FREQ_EXT_11_2896,
    FREQ_EXT_12_0_OR_12_288,
    FREQ_EXT_16_8,
    FREQ_EXT_19_2
  } input_clk_freq_t;

  typedef enum logic [1:0] {
    CAP_WAIT_RELEASE,
    CAP_COUNTING,
    CAP_HOLD
  } capture_state_t;

endpackage : boot_id_pkg

// ==== rtl/device_id_and_boot_strap_regs.sv ====
// Device identity word on the scan port and boot strap capture with CPU read-out
`timescale 1ns/10ps
`include "boot_id_params.svh"

module device_id_and_boot_strap_regs #(
  // Arbitrary neutral identity codes
  parameter logic [3:0]  ID_REVISION = 4'h1,
  parameter logic [15:0] ID_PART     = 16'h1234,
  parameter logic [10:0] ID_MAKER    = 11'h0AB
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  // Device pins, asynchronous
  input  wire logic                          reset_pin_low_active,
  input  wire logic [5:0]                    ext_mem_addr_pins,
  input  wire logic [5:0]                    general_io_pins,
  input  wire logic                          strap_from_gpio,
  input  wire logic                          clock_source_pin,
  // Scan port, same clock
  input  wire logic                          scan_capture,
  input  wire logic                          scan_shift,
  input  wire logic                          scan_tdi,
  output logic                               scan_tdo,
  // CPU register port
  input  wire logic                          cpu_sel,
  input  wire logic                          cpu_we,
  input  wire logic [15:0]                   cpu_addr,
  output logic [15:0]                        cpu_rdata,
  output logic                               cpu_ack,
  // Status outputs
  output logic [15:0]                        boot_strap_status,
  output logic                               clock_source_pin_state,
  output boot_id_pkg::input_clk_freq_t       input_clk_freq,
  output logic                               strap_valid
);
  import boot_id_pkg::*;

  // Fields placed by the layout constants; bit 0 forced so no maker code can clear it
  function automatic logic [31:0] id_word_build();
    logic [31:0] word;
    word                              = 32'h00000000;
    word[`ID_REV_MSB:`ID_REV_LSB]     = ID_REVISION;
    word[`ID_PART_MSB:`ID_PART_LSB]   = ID_PART;
    word[`ID_MAKER_MSB:`ID_MAKER_LSB] = ID_MAKER;
    word[`ID_FIXED_BIT]               = `ID_FIXED_VALUE;
    return word;
  endfunction : id_word_build

  localparam logic [31:0] ID_WORD = id_word_build();

  typedef struct packed {
    logic             rst_meta;
    logic             rst_sync;
    logic [5:0]       em_meta;
    logic [5:0]       em_sync;
    logic [5:0]       gp_meta;
    logic [5:0]       gp_sync;
    logic             grp_meta;
    logic             grp_sync;
    logic             clk_meta;
    logic             clk_sync;
    capture_state_t   cap_state;
    logic [3:0]       edge_cnt;
    logic [15:0]      strap;
    logic             clk_src;
    input_clk_freq_t  freq;
    logic             valid;
    logic [31:0]      shift;
    logic             tdo;
    logic [15:0]      rdata;
    logic             ack;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [5:0] strap_pins;

  always_comb begin
    next_cur = cur;

    // Two-flop synchronisers; first stage read only by the second
    // A longer chain would push the tenth-edge capture out of the allowed window
    next_cur.rst_meta = reset_pin_low_active;
    next_cur.rst_sync = cur.rst_meta;
    next_cur.em_meta  = ext_mem_addr_pins;
    next_cur.em_sync  = cur.em_meta;
    next_cur.gp_meta  = general_io_pins;
    next_cur.gp_sync  = cur.gp_meta;
    next_cur.grp_meta = strap_from_gpio;
    next_cur.grp_sync = cur.grp_meta;
    next_cur.clk_meta = clock_source_pin;
    next_cur.clk_sync = cur.clk_meta;

    strap_pins = cur.grp_sync ? cur.gp_sync : cur.em_sync;

    // Strap capture timed from the synchronised reset pin
    case (cur.cap_state)
      CAP_WAIT_RELEASE: begin
        if (cur.rst_sync) begin
          // The two sync edges plus this one are already spent
          next_cur.edge_cnt = `SYNC_EDGES + 4'h1;
          next_cur.strap[`STRAP_LO_MSB:`STRAP_LO_LSB] =
            strap_pins[`STRAP_LO_MSB-`STRAP_FIELD_LSB:0];
          next_cur.cap_state = CAP_COUNTING;
        end
      end
      CAP_COUNTING: begin
        if (!cur.rst_sync) begin
          next_cur.cap_state = CAP_WAIT_RELEASE;
        end else if (cur.edge_cnt == `STRAP_HI_EDGE - 4'h1) begin
          // edge_cnt holds the edges already spent, so this one is the tenth
          // Upper straps wait so slow clock-select straps can settle
          next_cur.strap[`STRAP_HI_MSB:`STRAP_HI_LSB] =
            strap_pins[`STRAP_FIELD_MSB-`STRAP_FIELD_LSB:
                       `STRAP_HI_LSB-`STRAP_FIELD_LSB];
          next_cur.valid     = 1'b1;
          next_cur.cap_state = CAP_HOLD;
        end else begin
          next_cur.edge_cnt = cur.edge_cnt + 4'h1;
        end
      end
      CAP_HOLD: begin
        // Values stay until the reset pin drops again
        // Metastability may add up to two edges, so readers wait for strap_valid
        // rather than counting edges themselves
        if (!cur.rst_sync) begin
          next_cur.valid     = 1'b0;
          next_cur.cap_state = CAP_WAIT_RELEASE;
        end
      end
      default: begin
        next_cur.cap_state = CAP_WAIT_RELEASE;
      end
    endcase

    // Reserved bits never loaded, so they stay zero
    next_cur.strap[15:11] = 5'h00;
    next_cur.strap[4:0]   = 5'h00;

    next_cur.clk_src = cur.clk_sync;

    // Input clock decode
    if (!cur.clk_sync) begin
      next_cur.freq = FREQ_OSC_12;
    end else begin
      case (cur.strap[`STRAP_HI_MSB:`STRAP_HI_LSB])
        2'h0:    next_cur.freq = FREQ_EXT_11_2896;
        2'h1:    next_cur.freq = FREQ_EXT_12_0_OR_12_288;
        2'h2:    next_cur.freq = FREQ_EXT_16_8;
        default: next_cur.freq = FREQ_EXT_19_2;
      endcase
    end

    // Scan port: capture reloads the constant; shifted-in bits enter at bit 31 and reach tdo only after 32 shifts
    if (scan_capture) begin
      next_cur.shift = ID_WORD;
      next_cur.tdo   = ID_WORD[0];
    end else if (scan_shift) begin
      next_cur.shift = {scan_tdi, cur.shift[31:1]};
      next_cur.tdo   = cur.shift[1];
    end

    // CPU port: one-cycle acknowledge, writes have no effect
    // Unmapped reads and writes return zero so no stale word is ever seen
    next_cur.ack   = cpu_sel;
    next_cur.rdata = 16'h0000;
    if (cpu_sel && !cpu_we) begin
      if (cpu_addr == `BOOT_STRAP_ADDR) begin
        next_cur.rdata = cur.strap;
      end else if (cpu_addr == `CLK_CONFIG_TWO_ADDR) begin
        next_cur.rdata[`CLK_SRC_STATE_BIT] = cur.clk_src;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur.rst_meta  <= 1'b0;
      cur.rst_sync  <= 1'b0;
      cur.em_meta   <= 6'h00;
      cur.em_sync   <= 6'h00;
      cur.gp_meta   <= 6'h00;
      cur.gp_sync   <= 6'h00;
      cur.grp_meta  <= 1'b0;
      cur.grp_sync  <= 1'b0;
      cur.clk_meta  <= 1'b0;
      cur.clk_sync  <= 1'b0;
      cur.cap_state <= CAP_WAIT_RELEASE;
      cur.edge_cnt  <= 4'h0;
      cur.strap     <= `STRAP_RESET;
      cur.clk_src   <= 1'b0;
      cur.freq      <= FREQ_OSC_12;
      cur.valid     <= 1'b0;
      cur.shift     <= 32'h00000000;
      cur.tdo       <= 1'b0;
      cur.rdata     <= 16'h0000;
      cur.ack       <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign scan_tdo               = cur.tdo;
  assign cpu_rdata              = cur.rdata;
  assign cpu_ack                = cur.ack;
  assign boot_strap_status      = cur.strap;
  assign clock_source_pin_state = cur.clk_src;
  assign input_clk_freq         = cur.freq;
  assign strap_valid            = cur.valid;

endmodule : device_id_and_boot_strap_regs

// ==== verification/boot_id_sva.sv ====
// Port checks for the identity and boot strap block
`timescale 1ns/10ps

module boot_id_sva
  import boot_id_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rstn,
  // Pins and scan port
  input wire logic             reset_pin_low_active,
  input wire logic             scan_capture,
  input wire logic             scan_tdo,
  // CPU port
  input wire logic             cpu_sel,
  input wire logic             cpu_we,
  input wire logic [15:0]      cpu_addr,
  input wire logic [15:0]      cpu_rdata,
  input wire logic             cpu_ack,
  // Status
  input wire logic [15:0]      boot_strap_status,
  input wire logic             clock_source_pin_state,
  input wire input_clk_freq_t  input_clk_freq,
  input wire logic             strap_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence pin_up;
    $rose(reset_pin_low_active);
  endsequence
  // Pin must stay up, else the count restarts
  sequence pin_held;
    pin_up ##1 reset_pin_low_active [*8];
  endsequence
  // No capture before the tenth edge after the rise
  sequence no_capture_yet;
    !strap_valid [*8] ##1 !strap_valid ##1 !strap_valid;
  endsequence

  chk_ack_follows: assert property (cpu_ack == $past(cpu_sel))
    else $error("ack timing");
  chk_strap_read: assert property (
    cpu_sel && !cpu_we && cpu_addr == 16'h1C34 && strap_valid && $past(strap_valid)
    |=> cpu_rdata == boot_strap_status) else $error("strap read");
  chk_clk_state: assert property (
    cpu_sel && !cpu_we && cpu_addr == 16'h1C1F
    |=> cpu_rdata == {13'h0000, $past(clock_source_pin_state), 2'b00})
    else $error("clock cfg read");
  chk_write_quiet: assert property (
    cpu_sel && cpu_we |=> cpu_rdata == 16'h0000) else $error("write data");
  chk_rsvd_zero: assert property (
    boot_strap_status[15:11] == 5'h00 && boot_strap_status[4:0] == 5'h00)
    else $error("reserved bits");
  chk_hold_latched: assert property (
    strap_valid && $past(strap_valid) && $past(strap_valid, 2)
    |-> $stable(boot_strap_status)) else $error("strap moved");
  chk_capture_late: assert property (pin_up |-> no_capture_yet)
    else $error("capture early");
  chk_capture_window: assert property (pin_held |-> ##[2:4] strap_valid)
    else $error("capture late");
  chk_osc_low: assert property (
    !clock_source_pin_state && !$past(clock_source_pin_state)
    |-> input_clk_freq == FREQ_OSC_12) else $error("osc decode");
  chk_ext_decode: assert property (
    clock_source_pin_state && $past(clock_source_pin_state)
    && strap_valid && $past(strap_valid, 2)
    |-> input_clk_freq == input_clk_freq_t'({1'b0, boot_strap_status[10:9]} + 3'h1))
    else $error("ext decode");
  chk_id_lsb: assert property (scan_capture |=> scan_tdo)
    else $error("id lsb");
endmodule : boot_id_sva

bind device_id_and_boot_strap_regs boot_id_sva boot_id_sva_inst (.sys_clk, .rstn,
  .reset_pin_low_active, .scan_capture, .scan_tdo, .cpu_sel, .cpu_we, .cpu_addr, .cpu_rdata,
  .cpu_ack, .boot_strap_status, .clock_source_pin_state, .input_clk_freq, .strap_valid);

// ==== verification/scan_host.sv ====
// Scan controller model that reads the identity word
`timescale 1ns/10ps

module scan_host (
  // Clock and serial return
  input wire logic  sys_clk,
  input wire logic  scan_tdo,
  // Controls
  output logic      scan_capture = 1'b0,
  output logic      scan_shift = 1'b0,
  output logic      scan_tdi = 1'b0
);
  // Feeds pat on tdi while shifting so a leak into the word shows
  task read_id(input logic [31:0] pat, output logic [31:0] w);
    @(negedge sys_clk);
    scan_capture = 1'b1;
    @(negedge sys_clk);
    scan_capture = 1'b0;
    scan_shift = 1'b1;
    w[0] = scan_tdo;
    for (int i = 1; i < 32; i++) begin
      scan_tdi = pat[i];
      @(negedge sys_clk);
      w[i] = scan_tdo;
    end
    scan_shift = 1'b0;
  endtask : read_id
endmodule : scan_host

// ==== verification/tb_top.sv ====
// Self-checking bench for the identity and boot strap block
`timescale 1ns/10ps

module tb_top;
  import boot_id_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, reset_pin_low_active = 1'b0;
  logic strap_from_gpio = 1'b0, clock_source_pin = 1'b0, cpu_sel = 1'b0, cpu_we = 1'b0;
  logic [5:0] ext_mem_addr_pins = 6'h00, general_io_pins = 6'h00;
  logic [15:0] cpu_addr = 16'h0000, cpu_rdata, boot_strap_status, d, s;
  logic scan_capture, scan_shift, scan_tdi, scan_tdo, cpu_ack, clock_source_pin_state, strap_valid;
  input_clk_freq_t input_clk_freq;
  logic [31:0] w;
  int errors = 0, samples_checked = 0, cycles = 0;

  device_id_and_boot_strap_regs device_id_and_boot_strap_regs_inst (.sys_clk, .rstn,
    .reset_pin_low_active, .ext_mem_addr_pins, .general_io_pins, .strap_from_gpio,
    .clock_source_pin, .scan_capture, .scan_shift, .scan_tdi, .scan_tdo, .cpu_sel, .cpu_we,
    .cpu_addr, .cpu_rdata, .cpu_ack, .boot_strap_status, .clock_source_pin_state,
    .input_clk_freq, .strap_valid);
  scan_host scan_host_inst (.sys_clk, .scan_tdo, .scan_capture, .scan_shift, .scan_tdi);

  always #5 sys_clk = ~sys_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task acc(input logic [15:0] a, input logic we, output logic [15:0] q);
    @(negedge sys_clk);
    cpu_sel = 1'b1;
    cpu_we = we;
    cpu_addr = a;
    @(negedge sys_clk);
    cpu_sel = 1'b0;
    chk({31'h0, cpu_ack}, 32'h1);
    q = cpu_rdata;
  endtask : acc

  // Groups differ in low bits so a wrong group choice shows
  task boot(input logic [1:0] k, input logic g, input logic c);
    @(negedge sys_clk);
    reset_pin_low_active = 1'b0;
    ext_mem_addr_pins = {k, 4'hA};
    general_io_pins = {k, 4'h5};
    strap_from_gpio = g;
    clock_source_pin = c;
    repeat (6) @(negedge sys_clk);
    reset_pin_low_active = 1'b1;
    repeat (9) @(negedge sys_clk);
    chk({31'h0, strap_valid}, 32'h0);
    @(negedge sys_clk);
    chk({31'h0, strap_valid}, 32'h1);
    repeat (6) @(negedge sys_clk);
    ext_mem_addr_pins = ~ext_mem_addr_pins;
    general_io_pins = ~general_io_pins;
  endtask : boot

  task conclude;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      boot(i[1:0], i[0] ^ i[2], i[2]);
      s = {5'h00, i[1:0], (i[0] ^ i[2]) ? 4'h5 : 4'hA, 5'h00};
      acc(16'h1C34, 1'b0, d);
      chk({16'h0, d}, {16'h0, s});
      acc(16'h1C34, 1'b1, d);
      acc(16'h1C34, 1'b0, d);
      chk({16'h0, d}, {16'h0, s});
      acc(16'h1C1F, 1'b0, d);
      chk({16'h0, d}, {29'h0, i[2], 2'b00});
      chk({29'h0, input_clk_freq}, {29'h0, i[2] ? {1'b0, i[1:0]} + 3'h1 : 3'h0});
      chk({16'h0, boot_strap_status}, {16'h0, s});
      chk({31'h0, clock_source_pin_state}, {31'h0, i[2]});
    end
    acc(16'h1C35, 1'b0, d);
    chk({16'h0, d}, 32'h0);
    scan_host_inst.read_id(32'h0000_0000, w);
    chk(w, {4'h1, 16'h1234, 11'h0AB, 1'b1});
    scan_host_inst.read_id(32'hFFFF_FFFF, w);
    chk(w, {4'h1, 16'h1234, 11'h0AB, 1'b1});
    conclude();
  end
endmodule : tb_top
